// ==== pmi_dev.sv ====
`timescale 1ns/100ps
`include "pmi_map.svh"
module pmi_dev #(
  parameter int unsigned TOUT_CYC = `PMI_TOUT_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Two-wire bus
  pmi_if.dev bus,
  // Address straps as two-bit codes
  input wire logic [1:0] addr_strap_low,
  input wire logic [1:0] addr_strap_high,
  // Measurement results
  input wire logic [15:0] shunt_val,
  input wire logic [15:0] busv_val,
  input wire logic [15:0] power_val,
  input wire logic [15:0] curr_val,
  input wire logic alert_req,
  // Settings towards the measurement engine
  output logic [15:0] cfg_word,
  output logic [15:0] cal_word,
  output logic [15:0] mask_word,
  output logic [15:0] limit_word,
  output logic cfg_wr,
  output logic soft_rst
);

  localparam pmi_pkg::pmi_dev_type RST_VAL = '{st: pmi_pkg::DS_IDLE,
    scl_s: 2'h3, sda_s: 2'h3, scl_f: 1'b1, sda_f: 1'b1,
    cfg: `PMI_CFG_DEF, alert_n: 1'b1, default: '0};

  pmi_pkg::pmi_dev_type s_q;
  pmi_pkg::pmi_dev_type s_d;
  logic [2:0] f_scl;
  logic [2:0] f_sda;
  logic [1:0] flen;
  logic scl_r;
  logic scl_fl;
  logic start;
  logic stop;
  logic tout_hit;
  logic [15:0] rd_word;
  logic [15:0] wr_word;

  // Glitch filter: a new level must persist for len cycles
  function automatic logic [2:0] filt(input logic raw, input logic cur,
      input logic [1:0] cnt, input logic [1:0] len);
    filt = {cur, 2'h0};
    if (raw != cur) begin
      if (cnt + 2'h1 >= len) begin
        filt = {raw, 2'h0};
      end else begin
        filt = {cur, 2'(cnt + 2'h1)};
      end
    end
  endfunction : filt

  // Register read mux
  always_comb begin
    case (s_q.ptr)
      `PMI_REG_CFG: rd_word = s_q.cfg;
      `PMI_REG_SHUNT: rd_word = shunt_val;
      `PMI_REG_BUSV: rd_word = busv_val;
      `PMI_REG_POWER: rd_word = (|s_q.cal) ? power_val : 16'h0000;
      `PMI_REG_CURR: rd_word = (|s_q.cal) ? curr_val : 16'h0000;
      `PMI_REG_CAL: rd_word = s_q.cal;
      `PMI_REG_MASK: rd_word = s_q.mask;
      `PMI_REG_LIM: rd_word = s_q.lim;
      default: rd_word = 16'h0000;
    endcase
  end

  // Whole next state
  always_comb begin
    s_d = s_q;
    s_d.cfg_wr = 1'b0;
    s_d.soft_rst = 1'b0;
    s_d.alert_n = ~alert_req;
    // Only the second stage of each synchroniser is read below
    s_d.scl_s = {s_q.scl_s[0], bus.scl};
    s_d.sda_s = {s_q.sda_s[0], bus.sda};
    s_d.strap_s = {s_q.strap_s[3:0], addr_strap_high, addr_strap_low};
    flen = s_q.hs ? `PMI_FILT_HS : `PMI_FILT_FS;
    f_scl = filt(s_q.scl_s[1], s_q.scl_f, s_q.scl_c, flen);
    f_sda = filt(s_q.sda_s[1], s_q.sda_f, s_q.sda_c, flen);
    {s_d.scl_f, s_d.scl_c} = f_scl;
    {s_d.sda_f, s_d.sda_c} = f_sda;
    scl_r = f_scl[2] & ~s_q.scl_f;
    scl_fl = ~f_scl[2] & s_q.scl_f;
    start = s_q.scl_f & f_scl[2] & s_q.sda_f & ~f_sda[2];
    stop = s_q.scl_f & f_scl[2] & ~s_q.sda_f & f_sda[2];
    wr_word = {s_q.hold, s_q.sh};
    tout_hit = s_q.tout >= TOUT_CYC[19:0] - 20'h1;
    // Timeout counts only while a transfer is open and the clock is idle
    if (s_q.st == pmi_pkg::DS_IDLE || scl_r || scl_fl) begin
      s_d.tout = '0;
    end else begin
      s_d.tout = s_q.tout + 20'h1;
    end
    if (stop) begin
      s_d.st = pmi_pkg::DS_IDLE;
      s_d.hs = 1'b0;
      s_d.sda_oe = 1'b0;
    end else if (start) begin
      s_d.st = pmi_pkg::DS_ADDR;
      s_d.cnt = 4'h0;
      s_d.sda_oe = 1'b0;
      s_d.own = {`PMI_ADDR_BASE, s_q.strap_s[7:4]};
    end else if (s_q.st != pmi_pkg::DS_IDLE && tout_hit) begin
      s_d.st = pmi_pkg::DS_IDLE;
      s_d.sda_oe = 1'b0;
    end else if (scl_r) begin
      case (s_q.st)
        pmi_pkg::DS_ADDR, pmi_pkg::DS_RX: begin
          s_d.sh = {s_q.sh[6:0], f_sda[2]};
          s_d.cnt = s_q.cnt + 4'h1;
        end
        pmi_pkg::DS_TX: begin
          s_d.cnt = s_q.cnt + 4'h1;
          // Sending a one but the line is low: another slave won
          if (!s_q.sda_oe && !f_sda[2]) begin
            s_d.st = pmi_pkg::DS_IDLE;
          end
        end
        pmi_pkg::DS_MACK: s_d.mack = ~f_sda[2];
        default: ;
      endcase
    end else if (scl_fl) begin
      case (s_q.st)
        pmi_pkg::DS_ADDR: begin
          if (s_q.cnt == 4'h8) begin
            s_d.ara = 1'b0;
            s_d.bidx = 2'h0;
            s_d.rw = s_q.sh[0];
            if (s_q.sh[7:3] == `PMI_HS_CODE) begin
              s_d.hs = 1'b1;
              s_d.st = pmi_pkg::DS_IDLE;
            end else if (s_q.sh[7:1] == s_q.own) begin
              s_d.sda_oe = 1'b1;
              s_d.st = pmi_pkg::DS_AACK;
            end else if (s_q.sh == {`PMI_ARA_ADDR, 1'b1} && alert_req) begin
              s_d.sda_oe = 1'b1;
              s_d.ara = 1'b1;
              s_d.st = pmi_pkg::DS_AACK;
            end else begin
              s_d.st = pmi_pkg::DS_IDLE;
            end
          end
        end
        pmi_pkg::DS_AACK: begin
          s_d.cnt = 4'h0;
          if (s_q.rw) begin
            s_d.txb = s_q.ara ? {s_q.own, 1'b0} : rd_word[15:8];
            s_d.sda_oe = s_q.ara ? ~s_q.own[6] : ~rd_word[15];
            s_d.st = pmi_pkg::DS_TX;
          end else begin
            s_d.sda_oe = 1'b0;
            s_d.st = pmi_pkg::DS_RX;
          end
        end
        pmi_pkg::DS_RX: begin
          if (s_q.cnt == 4'h8) begin
            s_d.sda_oe = 1'b1;
            s_d.st = pmi_pkg::DS_RACK;
            case (s_q.bidx)
              2'h0: begin
                s_d.ptr = s_q.sh;
                s_d.bidx = 2'h1;
              end
              2'h1: begin
                s_d.hold = s_q.sh;
                s_d.bidx = 2'h2;
              end
              default: begin
                // Further byte pairs rewrite the same register
                s_d.bidx = 2'h1;
                if (s_q.ptr == `PMI_REG_CFG) begin
                  if (wr_word[`PMI_CFG_RST_BIT]) begin
                    s_d.soft_rst = 1'b1;
                    s_d.cfg = `PMI_CFG_DEF;
                    s_d.cal = 16'h0000;
                    s_d.mask = 16'h0000;
                    s_d.lim = 16'h0000;
                  end else begin
                    s_d.cfg = wr_word;
                    s_d.cfg_wr = 1'b1;
                  end
                end else if (s_q.ptr == `PMI_REG_CAL) begin
                  s_d.cal = wr_word;
                end else if (s_q.ptr == `PMI_REG_MASK) begin
                  s_d.mask = wr_word;
                end else if (s_q.ptr == `PMI_REG_LIM) begin
                  s_d.lim = wr_word;
                end
              end
            endcase
          end
        end
        pmi_pkg::DS_RACK: begin
          s_d.sda_oe = 1'b0;
          s_d.cnt = 4'h0;
          s_d.st = pmi_pkg::DS_RX;
        end
        pmi_pkg::DS_TX: begin
          if (s_q.cnt == 4'h8) begin
            s_d.sda_oe = 1'b0;
            s_d.mack = 1'b0;
            s_d.st = pmi_pkg::DS_MACK;
          end else begin
            s_d.txb = {s_q.txb[6:0], 1'b0};
            s_d.sda_oe = ~s_q.txb[6];
          end
        end
        pmi_pkg::DS_MACK: begin
          s_d.cnt = 4'h0;
          if (s_q.mack && !s_q.ara) begin
            // Bytes alternate high, low while the master keeps acking
            s_d.bidx = {1'b0, ~s_q.bidx[0]};
            s_d.txb = s_q.bidx[0] ? rd_word[15:8] : rd_word[7:0];
            s_d.sda_oe = s_q.bidx[0] ? ~rd_word[15] : ~rd_word[7];
            s_d.st = pmi_pkg::DS_TX;
          end else begin
            s_d.st = pmi_pkg::DS_IDLE;
          end
        end
        default: ;
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= RST_VAL;
    end else begin
      s_q <= s_d;
    end
  end

  // Only the data and alert lines are ever driven
  assign bus.dev_sda_o = s_q.lo;
  assign bus.dev_sda_oe = s_q.sda_oe;
  assign bus.alert_n = s_q.alert_n;
  assign cfg_word = s_q.cfg;
  assign cal_word = s_q.cal;
  assign mask_word = s_q.mask;
  assign limit_word = s_q.lim;
  assign cfg_wr = s_q.cfg_wr;
  assign soft_rst = s_q.soft_rst;

endmodule : pmi_dev

// ==== pmi_map.svh ====
`ifndef PMI_MAP_SVH
`define PMI_MAP_SVH
// Core clock and bus rates
`define PMI_CLK_KHZ 20000
`define PMI_FS_KHZ 400
`define PMI_HS_KHZ 2500
// Quarter bit periods; least times round up
`define PMI_FS_QTR ((`PMI_CLK_KHZ / `PMI_FS_KHZ + 3) / 4)
// One spare cycle covers the two-stage sampling of the data line
`define PMI_HS_QTR ((`PMI_CLK_KHZ / `PMI_HS_KHZ + 3) / 4 + 1)
// Bus timeout
`define PMI_TOUT_MS 28
`define PMI_TOUT_CYC (`PMI_TOUT_MS * `PMI_CLK_KHZ)
`define PMI_TOUT_W 20
// Spike filter lengths in cycles
`define PMI_FILT_FS 2'h3
`define PMI_FILT_HS 2'h1
// Addresses and codes
`define PMI_ADDR_BASE 3'h4
`define PMI_ARA_ADDR 7'h0c
`define PMI_HS_CODE 5'h01
`define PMI_MCODE 8'h08
// Register pointers
`define PMI_REG_CFG 8'h00
`define PMI_REG_SHUNT 8'h01
`define PMI_REG_BUSV 8'h02
`define PMI_REG_POWER 8'h03
`define PMI_REG_CURR 8'h04
`define PMI_REG_CAL 8'h05
`define PMI_REG_MASK 8'h06
`define PMI_REG_LIM 8'h07
// Configuration reset value and soft reset bit
`define PMI_CFG_DEF 16'h4127
`define PMI_CFG_RST_BIT 15
`endif

// ==== pmi_pkg.sv ====
package pmi_pkg;

  // Slave bit engine states
  typedef enum logic [2:0] {
    DS_IDLE = 3'b000,
    DS_ADDR = 3'b001,
    DS_AACK = 3'b010,
    DS_RX = 3'b011,
    DS_RACK = 3'b100,
    DS_TX = 3'b101,
    DS_MACK = 3'b110
  } pmi_dst_type;

  typedef struct packed {
    pmi_dst_type st;
    logic [1:0] scl_s, sda_s;
    logic [7:0] strap_s;
    logic scl_f, sda_f;
    logic [1:0] scl_c, sda_c;
    logic [3:0] cnt;
    logic [7:0] sh, hold, txb, ptr;
    logic [1:0] bidx;
    logic rw, ara, mack, hs, sda_oe, lo;
    logic [6:0] own;
    logic [19:0] tout;
    logic [15:0] cfg, cal, mask, lim;
    logic cfg_wr, soft_rst, alert_n;
  } pmi_dev_type;

  // Master transfer kinds
  typedef enum logic [1:0] {
    OP_PTR = 2'b00,
    OP_WRITE = 2'b01,
    OP_READ = 2'b10,
    OP_ARA = 2'b11
  } pmi_op_type;

  typedef enum logic [1:0] {
    K_START = 2'b00,
    K_WR = 2'b01,
    K_RD = 2'b10,
    K_STOP = 2'b11
  } pmi_kind_type;

  typedef struct packed {
    pmi_kind_type kind;
    logic [2:0] sel;
  } pmi_step_type;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_NEXT = 3'b001,
    H_START = 3'b010,
    H_BIT = 3'b011,
    H_STOP = 3'b100
  } pmi_hst_type;

  typedef struct packed {
    pmi_hst_type st;
    logic [1:0] q;
    logic [3:0] div, step, bitn;
    logic rd;
    logic [2:0] sel;
    logic [7:0] txb, rxb;
    logic [15:0] rdata;
    logic nack, hs, c_hs, scl_oe, sda_oe, lo, done, ready;
    pmi_op_type op;
    logic [6:0] c_addr;
    logic [7:0] c_ptr;
    logic [15:0] c_wd;
    logic [1:0] sda_s;
  } pmi_host_type;

endpackage : pmi_pkg

// ==== pmi_if.sv ====
`timescale 1ns/100ps
interface pmi_if;
  // Resolved open-drain levels
  logic scl;
  logic sda;
  // Drivers of each end
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic alert_n;

  // Wired-AND with pull-ups
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~(host_sda_oe & ~host_sda_o) & ~(dev_sda_oe & ~dev_sda_o);

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe,
    output alert_n);
  modport host (input sda, output host_scl_o, output host_scl_oe,
    output host_sda_o, output host_sda_oe);
endinterface : pmi_if

// ==== pmi_host.sv ====
`timescale 1ns/100ps
`include "pmi_map.svh"
module pmi_host (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Two-wire bus
  pmi_if.host bus,
  // Command
  input wire logic cmd_valid,
  input wire pmi_pkg::pmi_op_type cmd_op,
  input wire logic cmd_hs,
  input wire logic [6:0] cmd_addr,
  input wire logic [7:0] cmd_ptr,
  input wire logic [15:0] cmd_wdata,
  // Answer
  output logic cmd_ready,
  output logic done,
  output logic [15:0] rdata,
  output logic nack
);

  localparam pmi_pkg::pmi_host_type RST_VAL = '{st: pmi_pkg::H_IDLE,
    op: pmi_pkg::OP_PTR, ready: 1'b1, sda_s: 2'h3, default: '0};

  pmi_pkg::pmi_host_type h_q;
  pmi_pkg::pmi_host_type h_d;
  pmi_pkg::pmi_step_type stp;
  logic tick;

  // Action list of each transfer, optional master code first
  function automatic pmi_pkg::pmi_step_type step_of(
      input pmi_pkg::pmi_op_type op, input logic hs, input logic [3:0] i);
    logic [3:0] j;
    j = hs ? 4'(i - 4'h2) : i;
    step_of = '{kind: pmi_pkg::K_STOP, sel: 3'h0};
    if (hs && i == 4'h0) begin
      step_of = '{kind: pmi_pkg::K_START, sel: 3'h0};
    end else if (hs && i == 4'h1) begin
      step_of = '{kind: pmi_pkg::K_WR, sel: 3'h0};
    end else if (j == 4'h0) begin
      step_of = '{kind: pmi_pkg::K_START, sel: 3'h0};
    end else if (j == 4'h1) begin
      step_of = '{kind: pmi_pkg::K_WR,
        sel: (op == pmi_pkg::OP_ARA) ? 3'h6 : 3'h1};
    end else if (op == pmi_pkg::OP_ARA) begin
      if (j == 4'h2) step_of = '{kind: pmi_pkg::K_RD, sel: 3'h1};
    end else if (j == 4'h2) begin
      step_of = '{kind: pmi_pkg::K_WR, sel: 3'h2};
    end else if (op == pmi_pkg::OP_WRITE && j < 4'h5) begin
      step_of = '{kind: pmi_pkg::K_WR, sel: 3'(j)};
    end else if (op == pmi_pkg::OP_READ && j == 4'h3) begin
      step_of = '{kind: pmi_pkg::K_START, sel: 3'h0};
    end else if (op == pmi_pkg::OP_READ && j == 4'h4) begin
      step_of = '{kind: pmi_pkg::K_WR, sel: 3'h5};
    end else if (op == pmi_pkg::OP_READ && j < 4'h7) begin
      step_of = '{kind: pmi_pkg::K_RD, sel: 3'(j - 4'h5)};
    end
  endfunction : step_of

  // Next state
  always_comb begin
    h_d = h_q;
    h_d.done = 1'b0;
    h_d.sda_s = {h_q.sda_s[0], bus.sda};
    stp = step_of(h_q.op, h_q.c_hs, h_q.step);
    // Quarter-bit enable; rate follows the speed mode
    tick = (h_q.div == 4'h0);
    if (h_q.st == pmi_pkg::H_IDLE || tick) begin
      h_d.div = h_q.hs ? 4'(`PMI_HS_QTR - 1) : 4'(`PMI_FS_QTR - 1);
    end else begin
      h_d.div = h_q.div - 4'h1;
    end
    case (h_q.st)
      pmi_pkg::H_IDLE: begin
        if (cmd_valid) begin
          h_d = '{st: pmi_pkg::H_NEXT, op: cmd_op, c_hs: cmd_hs,
            c_addr: cmd_addr, c_ptr: cmd_ptr, c_wd: cmd_wdata,
            sda_s: h_d.sda_s, rdata: h_q.rdata, div: h_d.div,
            default: '0};
        end
      end
      pmi_pkg::H_NEXT: begin
        h_d.q = 2'h0;
        h_d.bitn = 4'h0;
        h_d.sel = stp.sel;
        h_d.rd = (stp.kind == pmi_pkg::K_RD);
        case (stp.sel)
          3'h0: h_d.txb = `PMI_MCODE;
          3'h1: h_d.txb = {h_q.c_addr, 1'b0};
          3'h2: h_d.txb = h_q.c_ptr;
          3'h3: h_d.txb = h_q.c_wd[15:8];
          3'h4: h_d.txb = h_q.c_wd[7:0];
          3'h5: h_d.txb = {h_q.c_addr, 1'b1};
          default: h_d.txb = {`PMI_ARA_ADDR, 1'b1};
        endcase
        case (stp.kind)
          pmi_pkg::K_START: begin
            h_d.st = pmi_pkg::H_START;
            h_d.hs = h_q.c_hs && (h_q.step != 4'h0);
          end
          pmi_pkg::K_STOP: h_d.st = pmi_pkg::H_STOP;
          default: h_d.st = pmi_pkg::H_BIT;
        endcase
      end
      pmi_pkg::H_START: begin
        if (tick) begin
          h_d.q = h_q.q + 2'h1;
          case (h_q.q)
            2'h0: h_d.sda_oe = 1'b0;
            2'h1: h_d.scl_oe = 1'b0;
            2'h2: h_d.sda_oe = 1'b1;
            default: begin
              h_d.scl_oe = 1'b1;
              h_d.step = h_q.step + 4'h1;
              h_d.st = pmi_pkg::H_NEXT;
            end
          endcase
        end
      end
      pmi_pkg::H_BIT: begin
        if (tick) begin
          h_d.q = h_q.q + 2'h1;
          case (h_q.q)
            2'h0: begin
              // Data changes only while the clock is low
              if (h_q.bitn == 4'h8) h_d.sda_oe = h_q.rd && h_q.sel == 3'h0;
              else h_d.sda_oe = !h_q.rd && !h_q.txb[7];
            end
            2'h1: h_d.scl_oe = 1'b0;
            2'h2: begin
              if (h_q.rd && h_q.bitn != 4'h8) begin
                h_d.rxb = {h_q.rxb[6:0], h_q.sda_s[1]};
              end
              if (!h_q.rd && h_q.bitn == 4'h8) h_d.nack = h_q.sda_s[1];
            end
            default: begin
              h_d.scl_oe = 1'b1;
              h_d.bitn = h_q.bitn + 4'h1;
              h_d.txb = {h_q.txb[6:0], 1'b0};
              if (h_q.bitn == 4'h8) begin
                h_d.step = h_q.step + 4'h1;
                h_d.st = pmi_pkg::H_NEXT;
                if (h_q.rd && h_q.sel == 3'h0) h_d.rdata[15:8] = h_q.rxb;
                if (h_q.rd && h_q.sel != 3'h0) h_d.rdata[7:0] = h_q.rxb;
                // A refused byte other than the master code aborts
                if (h_d.nack && h_q.sel != 3'h0 && !h_q.rd) begin
                  h_d.st = pmi_pkg::H_STOP;
                end else begin
                  h_d.nack = 1'b0;
                end
              end
            end
          endcase
        end
      end
      pmi_pkg::H_STOP: begin
        if (tick) begin
          h_d.q = h_q.q + 2'h1;
          case (h_q.q)
            2'h0: h_d.sda_oe = 1'b1;
            2'h1: h_d.scl_oe = 1'b0;
            2'h2: h_d.sda_oe = 1'b0;
            default: begin
              h_d.hs = 1'b0;
              h_d.done = 1'b1;
              h_d.ready = 1'b1;
              h_d.st = pmi_pkg::H_IDLE;
            end
          endcase
        end
      end
      default: h_d.st = pmi_pkg::H_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      h_q <= RST_VAL;
    end else begin
      h_q <= h_d;
    end
  end

  assign bus.host_scl_o = h_q.lo;
  assign bus.host_scl_oe = h_q.scl_oe;
  assign bus.host_sda_o = h_q.lo;
  assign bus.host_sda_oe = h_q.sda_oe;
  assign cmd_ready = h_q.ready;
  assign done = h_q.done;
  assign rdata = h_q.rdata;
  assign nack = h_q.nack;

endmodule : pmi_host

// ==== pmi_properties.sv ====
`timescale 1ns/100ps
module pmi_properties (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Resolved lines
  input wire logic scl,
  input wire logic sda,
  // Drivers of both ends
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic alert_n
);
  typedef struct packed {
    logic scl, sda, first;
    logic [3:0] bits;
    logic [7:0] sh;
  } pmi_mon_type;
  pmi_mon_type st_q, st_d;
  logic rise, start, stop, ninth;

  // Bus events as seen by the core clock
  assign rise = scl & ~st_q.scl;
  assign start = scl & st_q.scl & st_q.sda & ~sda;
  assign stop = scl & st_q.scl & ~st_q.sda & sda;
  assign ninth = rise & st_q.first & (st_q.bits == 4'h8);

  // Shift address bits; the ninth pulse is the ack slot, not data
  always_comb begin
    st_d = st_q;
    st_d.scl = scl;
    st_d.sda = sda;
    if (start) begin
      st_d.bits = 4'h0;
      st_d.first = 1'b1;
    end else if (rise) begin
      st_d.bits = (st_q.bits == 4'h9) ? 4'h1 : st_q.bits + 4'h1;
      if (st_q.bits == 4'h9) st_d.first = 1'b0;
      if (st_q.bits != 4'h8) st_d.sh = {st_q.sh[6:0], sda};
    end
  end

  // Idle bus reads high on both lines
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) st_q <= '{scl: 1'b1, sda: 1'b1, default: '0};
    else st_q <= st_d;
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  dev_drain_a: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("Device drives sda high");
  host_clock_a: assert property (!scl |-> host_scl_oe && !host_scl_o)
    else $error("Clock low without the host pulling it");
  sda_hold_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("Device changed sda while scl high");
  addr_quiet_a: assert property (st_q.first && st_q.bits < 4'h8
    |-> !dev_sda_oe) else $error("Device drove sda in address bits");
  // Own range is 100xxxx, so only the top three address bits are fixed
  foreign_nack_a: assert property (ninth && st_q.sh[7:1] != 7'h0c
    && st_q.sh[7:5] != 3'h4 |-> !dev_sda_oe)
    else $error("Device acked a foreign address");
  mcode_nack_a: assert property (ninth && st_q.sh == 8'h08
    |-> !dev_sda_oe) else $error("Device acked the master code");
  stop_release_a: assert property (stop |=> !dev_sda_oe [*8])
    else $error("Device drives sda after stop");
  scl_high_a: assert property ($rose(scl) |-> scl [*4])
    else $error("Clock high phase too short");
  scl_low_a: assert property ($fell(scl) |-> !scl [*4])
    else $error("Clock low phase too short");
endmodule : pmi_properties

// ==== tb.sv ====
`timescale 1ns/100ps
module tb;
  // Stimulus, answers and expected register image
  logic core_clk, rstn, cmd_valid, cmd_hs, alert_req;
  pmi_pkg::pmi_op_type cmd_op;
  logic [6:0] cmd_addr;
  logic [7:0] cmd_ptr, p_sel;
  logic [1:0] addr_strap_low, addr_strap_high;
  logic [15:0] cmd_wdata, shunt_val, busv_val, power_val, curr_val, rdata;
  logic [15:0] cfg_word, cal_word, mask_word, limit_word, d;
  logic cmd_ready, done, nack, cfg_wr, soft_rst;
  logic [15:0] m_reg [0:7];
  int error_cnt = 0;
  int check_count = 0;
  int n_cfg = 0;
  int n_srst = 0;
  pmi_if bus();

  pmi_dev #(.TOUT_CYC(2000)) u_pmi_dev (.core_clk, .rstn, .bus(bus.dev),
    .addr_strap_low, .addr_strap_high, .shunt_val, .busv_val, .power_val,
    .curr_val, .alert_req, .cfg_word, .cal_word, .mask_word, .limit_word,
    .cfg_wr, .soft_rst);
  pmi_host u_pmi_host (.core_clk, .rstn, .bus(bus.host), .cmd_valid,
    .cmd_op, .cmd_hs, .cmd_addr, .cmd_ptr, .cmd_wdata, .cmd_ready, .done,
    .rdata, .nack);
  pmi_properties u_pmi_properties (.core_clk, .rstn, .scl(bus.scl),
    .sda(bus.sda), .host_scl_o(bus.host_scl_o),
    .host_scl_oe(bus.host_scl_oe), .host_sda_o(bus.host_sda_o),
    .host_sda_oe(bus.host_sda_oe), .dev_sda_o(bus.dev_sda_o),
    .dev_sda_oe(bus.dev_sda_oe), .alert_n(bus.alert_n));

  // Core clock, 50 ns
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Count one-cycle setting pulses
  always @(posedge core_clk) begin
    if (cfg_wr === 1'b1) n_cfg++;
    if (soft_rst === 1'b1) n_srst++;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [6:0] own();
    return {3'h4, addr_strap_high, addr_strap_low};
  endfunction : own

  // Unwritten power and current read zero until calibrated
  function automatic logic [15:0] exp_rd(input logic [7:0] p);
    case (p)
      8'h01: return shunt_val;
      8'h02: return busv_val;
      8'h03: return (m_reg[5] == 16'h0) ? 16'h0 : power_val;
      8'h04: return (m_reg[5] == 16'h0) ? 16'h0 : curr_val;
      8'h00, 8'h05, 8'h06, 8'h07: return m_reg[p[2:0]];
      default: return 16'h0;
    endcase
  endfunction : exp_rd

  task automatic mdl_rst();
    foreach (m_reg[i]) m_reg[i] = 16'h0;
    m_reg[0] = 16'h4127;
  endtask : mdl_rst

  // One command; held until the edge that takes it
  task automatic run(input pmi_pkg::pmi_op_type op, input logic [6:0] a,
      input logic [7:0] p);
    @(posedge core_clk);
    #1;
    cmd_op = op;
    cmd_hs = 1'($urandom);
    cmd_addr = a;
    cmd_ptr = p;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
    for (int i = 0; i < 9000 && done !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk(16'(done), 16'h1);
  endtask : run

  task automatic wr(input logic [7:0] p);
    run(pmi_pkg::OP_WRITE, own(), p);
    chk(16'(nack), 16'h0);
    if (p == 8'h00 && d[15]) mdl_rst();
    else if (p == 8'h00 || (p > 8'h04 && p < 8'h08)) m_reg[p[2:0]] = d;
  endtask : wr

  task automatic rd(input logic [7:0] p);
    run(pmi_pkg::OP_READ, own(), p);
    chk(rdata, exp_rd(p));
  endtask : rd

  task automatic conclude();
    $display("TB: %0d checks, %0d mismatches", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  // Main sequence
  initial begin
    rstn = 1'b0;
    cmd_valid = 1'b0;
    cmd_hs = 1'b0;
    cmd_op = pmi_pkg::OP_PTR;
    {cmd_addr, cmd_ptr, cmd_wdata, d, p_sel} = '0;
    {addr_strap_low, addr_strap_high, alert_req} = '0;
    void'($urandom(85));
    {shunt_val, busv_val} = {16'($urandom), 16'($urandom)};
    {power_val, curr_val} = {16'($urandom), 16'($urandom)};
    mdl_rst();
    repeat (6) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    repeat (3) @(posedge core_clk);
    chk(cfg_word, 16'h4127);
    for (int p = 0; p < 5; p++) rd(8'(p));
    $display("TB: power-on test done");
    // Corner strap codes first, then random ones
    for (int i = 0; i < 8; i++) begin
      {addr_strap_high, addr_strap_low} = (i < 2) ? 4'(i * 15) : 4'($urandom);
      d = 16'($urandom);
      wr(8'h07);
      chk(limit_word, m_reg[7]);
      run(pmi_pkg::OP_PTR, own() ^ 7'h10, 8'h00);
      chk(16'(nack), 16'h1);
    end
    $display("TB: address test done");
    for (int i = 0; i < 4; i++) begin
      p_sel = (i == 0) ? 8'h00 : 8'(i + 4);
      d = 16'($urandom);
      if (i == 0) d[15] = 1'b0;
      if (i == 1) d[0] = 1'b1;
      wr(p_sel);
      rd(p_sel);
    end
    chk(cfg_word, m_reg[0]);
    chk(cal_word, m_reg[5]);
    chk(mask_word, m_reg[6]);
    chk(16'(n_cfg), 16'h1);
    rd(8'h03);
    rd(8'h04);
    $display("TB: register test done");
    d = 16'($urandom);
    wr(8'h09);
    rd(8'h09);
    wr(8'h01);
    rd(8'h01);
    chk(limit_word, m_reg[7]);
    run(pmi_pkg::OP_PTR, own(), 8'h06);
    chk(16'(nack), 16'h0);
    chk(mask_word, m_reg[6]);
    rd(8'h06);
    d = 16'h8000 | 16'($urandom);
    wr(8'h00);
    chk(16'(n_srst), 16'h1);
    chk(cal_word, 16'h0);
    rd(8'h05);
    // Settings are lost on reset, so the host programs the calibration again
    d = 16'($urandom) | 16'h0001;
    wr(8'h05);
    chk(cal_word, m_reg[5]);
    $display("TB: pointer and soft reset test done");
    run(pmi_pkg::OP_ARA, 7'h0c, 8'h00);
    chk(16'(nack), 16'h1);
    alert_req = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk(16'(bus.alert_n), 16'h0);
    run(pmi_pkg::OP_ARA, 7'h0c, 8'h00);
    chk(16'(nack), 16'h0);
    chk({8'h00, rdata[7:0]}, {8'h00, own(), 1'b0});
    alert_req = 1'b0;
    $display("TB: alert test done");
    conclude();
  end

  // Cut a hang short well past the expected run length
  initial begin
    repeat (99000) @(posedge core_clk);
    error_cnt++;
    conclude();
  end
endmodule : tb
